// >>> logic/hdc_pkg.sv
// constants for the hub descriptor configuration register bank
`default_nettype none
package hdc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CUR_SELF = 8'h0e;
  localparam logic [7:0] OFF_CUR_BUS = 8'h0f;
  localparam logic [7:0] OFF_PWR_ON = 8'h10;
  localparam logic [7:0] OFF_LANG_UP = 8'h11;
  localparam logic [7:0] OFF_LANG_LO = 8'h12;
  localparam logic [7:0] OFF_MAKER_LEN = 8'h13;
  localparam logic [7:0] OFF_PROD_LEN = 8'h14;
  localparam logic [7:0] OFF_SER_LEN = 8'h15;
  localparam logic [7:0] OFF_MAKER_FIRST = 8'h16;
  localparam logic [7:0] OFF_MAKER_LAST = 8'h53;
  localparam logic [7:0] OFF_PROD_FIRST = 8'h54;
  localparam logic [7:0] OFF_PROD_LAST = 8'h91;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CUR_SELF = 8'h02;
  localparam logic [7:0] RST_CUR_BUS = 8'h64;
  localparam logic [7:0] RST_PWR_ON = 8'h00;
  localparam logic [7:0] RST_LANG_UP = 8'h04;
  localparam logic [7:0] RST_LANG_LO = 8'h09;
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam logic [7:0] RST_TEXT = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ----------------------------------------
  // string storage geometry and selectors
  // ----------------------------------------
  localparam int TEXT_BYTES = 62;
  localparam logic [5:0] TEXT_MAX = 6'h3e;
  localparam logic [1:0] SEL_MAKER = 2'h0;
  localparam logic [1:0] SEL_PROD = 2'h1;
  localparam logic [1:0] SEL_SERIAL = 2'h2;
  typedef enum logic [1:0] {
    HDC_IDLE = 2'b01,
    HDC_SEND = 2'b10
  } hdc_state_t;
endpackage
`default_nettype wire

// >>> logic/hdc_regs.sv
// hub descriptor configuration registers and string descriptor reader
`timescale 1ns/1ps
`default_nettype none
module hdc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration byte port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // string descriptor reader
  input wire logic desc_req,
  input wire logic [1:0] desc_sel,
  output logic desc_busy,
  output logic desc_valid,
  output logic [7:0] desc_data,
  output logic desc_last,
  output logic desc_done,
  // descriptor fields
  output logic [7:0] cur_self,
  output logic [7:0] cur_bus,
  output logic [7:0] pwr_good_time,
  output logic [15:0] lang_id
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_s;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_s <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [7:0] self_q, bus_q, pwr_q, lang_up_q, lang_lo_q;
  logic [7:0] maker_len_q, prod_len_q, ser_len_q;
  logic [7:0] maker_q [hdc_pkg::TEXT_BYTES];
  logic [7:0] prod_q [hdc_pkg::TEXT_BYTES];
  wire in_maker = (cfg_addr >= hdc_pkg::OFF_MAKER_FIRST) &&
                  (cfg_addr <= hdc_pkg::OFF_MAKER_LAST);
  wire in_prod = (cfg_addr >= hdc_pkg::OFF_PROD_FIRST) &&
                 (cfg_addr <= hdc_pkg::OFF_PROD_LAST);
  wire [7:0] maker_off = cfg_addr - hdc_pkg::OFF_MAKER_FIRST;
  wire [7:0] prod_off = cfg_addr - hdc_pkg::OFF_PROD_FIRST;
  wire [5:0] maker_idx = maker_off[5:0];
  wire [5:0] prod_idx = prod_off[5:0];
  wire wr_self = cfg_wr && (cfg_addr == hdc_pkg::OFF_CUR_SELF);
  wire wr_bus = cfg_wr && (cfg_addr == hdc_pkg::OFF_CUR_BUS);
  wire wr_pwr = cfg_wr && (cfg_addr == hdc_pkg::OFF_PWR_ON);
  wire wr_lup = cfg_wr && (cfg_addr == hdc_pkg::OFF_LANG_UP);
  wire wr_llo = cfg_wr && (cfg_addr == hdc_pkg::OFF_LANG_LO);
  wire wr_mlen = cfg_wr && (cfg_addr == hdc_pkg::OFF_MAKER_LEN);
  wire wr_plen = cfg_wr && (cfg_addr == hdc_pkg::OFF_PROD_LEN);
  wire wr_slen = cfg_wr && (cfg_addr == hdc_pkg::OFF_SER_LEN);
  wire wr_maker = cfg_wr && in_maker;
  wire wr_prod = cfg_wr && in_prod;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = hdc_pkg::RD_UNMAPPED;
    if (in_maker) rd_mux = maker_q[maker_idx];
    else if (in_prod) rd_mux = prod_q[prod_idx];
    else begin
      case (cfg_addr)
        hdc_pkg::OFF_CUR_SELF: rd_mux = self_q;
        hdc_pkg::OFF_CUR_BUS: rd_mux = bus_q;
        hdc_pkg::OFF_PWR_ON: rd_mux = pwr_q;
        hdc_pkg::OFF_LANG_UP: rd_mux = lang_up_q;
        hdc_pkg::OFF_LANG_LO: rd_mux = lang_lo_q;
        hdc_pkg::OFF_MAKER_LEN: rd_mux = maker_len_q;
        hdc_pkg::OFF_PROD_LEN: rd_mux = prod_len_q;
        hdc_pkg::OFF_SER_LEN: rd_mux = ser_len_q;
        default: rd_mux = hdc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------
  // scalar registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      self_q <= hdc_pkg::RST_CUR_SELF;
      bus_q <= hdc_pkg::RST_CUR_BUS;
      pwr_q <= hdc_pkg::RST_PWR_ON;
      lang_up_q <= hdc_pkg::RST_LANG_UP;
      lang_lo_q <= hdc_pkg::RST_LANG_LO;
      maker_len_q <= hdc_pkg::RST_LEN;
      prod_len_q <= hdc_pkg::RST_LEN;
      ser_len_q <= hdc_pkg::RST_LEN;
      cfg_rdata <= hdc_pkg::RD_UNMAPPED;
    end else begin
      if (wr_self) self_q <= cfg_wdata;
      if (wr_bus) bus_q <= cfg_wdata;
      if (wr_pwr) pwr_q <= cfg_wdata;
      if (wr_lup) lang_up_q <= cfg_wdata;
      if (wr_llo) lang_lo_q <= cfg_wdata;
      if (wr_mlen) maker_len_q <= cfg_wdata;
      if (wr_plen) prod_len_q <= cfg_wdata;
      if (wr_slen) ser_len_q <= cfg_wdata;
      if (cfg_rd) cfg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // string storage
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      for (int i = 0; i < hdc_pkg::TEXT_BYTES; i++) begin
        maker_q[i] <= hdc_pkg::RST_TEXT;
        prod_q[i] <= hdc_pkg::RST_TEXT;
      end
    end else begin
      if (wr_maker) maker_q[maker_idx] <= cfg_wdata;
      if (wr_prod) prod_q[prod_idx] <= cfg_wdata;
    end
  end

  // descriptor fields straight from the register flops
  assign cur_self = self_q;
  assign cur_bus = bus_q;
  assign pwr_good_time = pwr_q;
  assign lang_id = {lang_up_q, lang_lo_q};

  // ----------------------------------------
  // string descriptor reader
  // ----------------------------------------
  hdc_pkg::hdc_state_t state_q;
  logic [1:0] sel_q;
  logic [5:0] idx_q, cnt_q;
  logic [7:0] sel_len;
  always_comb begin
    case (desc_sel)
      hdc_pkg::SEL_MAKER: sel_len = maker_len_q;
      hdc_pkg::SEL_PROD: sel_len = prod_len_q;
      hdc_pkg::SEL_SERIAL: sel_len = ser_len_q;
      default: sel_len = hdc_pkg::RST_LEN;
    endcase
  end
  // lengths beyond the storage would read past it, so they are clamped
  wire len_big = sel_len > {2'b00, hdc_pkg::TEXT_MAX};
  wire [5:0] req_len = len_big ? hdc_pkg::TEXT_MAX : sel_len[5:0];
  // serial bytes live outside this bank; they stream as zero
  wire [7:0] str_byte = (sel_q == hdc_pkg::SEL_MAKER) ? maker_q[idx_q] :
                        (sel_q == hdc_pkg::SEL_PROD) ? prod_q[idx_q] :
                        hdc_pkg::RST_TEXT;
  wire at_last = (idx_q == cnt_q - 6'h01);
  wire accept = (state_q == hdc_pkg::HDC_IDLE) && desc_req;

  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      state_q <= hdc_pkg::HDC_IDLE;
      sel_q <= hdc_pkg::SEL_MAKER;
      idx_q <= 6'h00;
      cnt_q <= 6'h00;
      desc_busy <= 1'b0;
      desc_valid <= 1'b0;
      desc_data <= hdc_pkg::RST_TEXT;
      desc_last <= 1'b0;
      desc_done <= 1'b0;
    end else begin
      desc_valid <= 1'b0;
      desc_last <= 1'b0;
      desc_done <= 1'b0;
      case (state_q)
        hdc_pkg::HDC_IDLE: begin
          if (accept) begin
            sel_q <= desc_sel;
            idx_q <= 6'h00;
            cnt_q <= req_len;
            if (req_len == 6'h00) begin
              desc_done <= 1'b1;
            end else begin
              state_q <= hdc_pkg::HDC_SEND;
              desc_busy <= 1'b1;
            end
          end
        end
        hdc_pkg::HDC_SEND: begin
          desc_valid <= 1'b1;
          desc_data <= str_byte;
          desc_last <= at_last;
          idx_q <= idx_q + 6'h01;
          if (at_last) begin
            state_q <= hdc_pkg::HDC_IDLE;
            desc_busy <= 1'b0;
            desc_done <= 1'b1;
          end
        end
        default: begin
          state_q <= hdc_pkg::HDC_IDLE;
          desc_busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s);

  // beats are counted here, so no long repetition is unrolled
  logic [6:0] beats_q;
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) beats_q <= 7'h00;
    else if (desc_done) beats_q <= 7'h00;
    else if (desc_valid) beats_q <= beats_q + 7'h01;
  end

  sequence s_write(logic [7:0] off);
    cfg_wr && (cfg_addr == off);
  endsequence
  sequence s_readback(logic [7:0] off);
    cfg_rd && !cfg_wr && (cfg_addr == off);
  endsequence
  // a controller may leave a quiet edge between a write and its readback
  sequence s_write_gap_read(logic [7:0] off);
    s_write(off) ##1 !cfg_wr ##1 s_readback(off);
  endsequence
  sequence s_take_text;
    accept && (req_len != 6'h00);
  endsequence
  sequence s_take_empty;
    accept && (req_len == 6'h00);
  endsequence
  sequence s_final_beat;
    desc_valid && desc_last;
  endsequence

  // ----------------------------------------
  // register checks
  // ----------------------------------------
  // one access per edge on the byte port, so one write per check
  a_self_write: assert property (s_write(hdc_pkg::OFF_CUR_SELF) |=>
    cur_self == $past(cfg_wdata)) else $error("self current not stored");
  a_bus_write: assert property (s_write(hdc_pkg::OFF_CUR_BUS) |=>
    cur_bus == $past(cfg_wdata)) else $error("bus current not stored");
  a_bus_readback: assert property (s_write_gap_read(hdc_pkg::OFF_CUR_BUS) |=>
    cfg_rdata == $past(cfg_wdata, 3)) else $error("bus current readback wrong");
  // the delay must not disturb any other descriptor field
  a_pwr_isolated: assert property (s_write(hdc_pkg::OFF_PWR_ON) |=>
    $stable(cur_self) && $stable(cur_bus) && $stable(lang_id) &&
    pwr_good_time == $past(cfg_wdata)) else $error("power-on write leaked");
  a_lang_upper: assert property (s_write(hdc_pkg::OFF_LANG_UP) |=>
    lang_id[15:8] == $past(cfg_wdata) && $stable(lang_id[7:0]))
    else $error("language upper byte wrong");
  a_lang_lower: assert property (s_write(hdc_pkg::OFF_LANG_LO) |=>
    lang_id[7:0] == $past(cfg_wdata) && $stable(lang_id[15:8]))
    else $error("language lower byte wrong");
  a_len_readback: assert property (s_write_gap_read(hdc_pkg::OFF_SER_LEN) |=>
    cfg_rdata == $past(cfg_wdata, 3)) else $error("length readback wrong");
  a_maker_store: assert property (s_write_gap_read(hdc_pkg::OFF_MAKER_LAST) |=>
    cfg_rdata == $past(cfg_wdata, 3)) else $error("maker byte readback wrong");
  a_prod_store: assert property (s_write_gap_read(hdc_pkg::OFF_PROD_FIRST) |=>
    cfg_rdata == $past(cfg_wdata, 3)) else $error("product byte readback wrong");

  // ----------------------------------------
  // string reader checks
  // ----------------------------------------
  a_beat_count: assert property (desc_done |->
    (beats_q + {6'h00, desc_valid}) == {1'b0, cnt_q})
    else $error("string beats differ from length");
  a_start_lat: assert property (s_take_text |=> desc_busy ##1 desc_valid)
    else $error("string start late");
  // a length-zero request ends with done alone
  a_empty_text: assert property (s_take_empty |=>
    desc_done && !desc_valid && !desc_busy) else $error("empty string not ended alone");
  a_last_done: assert property (s_final_beat |-> desc_done && !desc_busy)
    else $error("final byte without done");
  a_busy_beat: assert property (desc_valid && !desc_last |-> desc_busy)
    else $error("byte streamed while idle");
  a_done_alone: assert property (desc_done && !desc_valid |-> !desc_busy && !desc_last)
    else $error("empty done not alone");
endmodule // hdc_regs
`default_nettype wire

// >>> sim/hdc_ctrl_model.sv
// system controller model that programs the configuration byte port
`timescale 1ns/1ps
`default_nettype none
module hdc_ctrl_model (
  // clock
  input wire logic clk,
  // configuration byte port
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  // ----------------------------------------
  // byte accesses, launched 1 ns after an edge
  // ----------------------------------------
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_wdata = ~d; // stale data never lingers on the bus
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask
  // ascii text as utf-16le, low byte first, ascending
  task automatic write_text(input logic [7:0] base, input string s);
    for (int i = 0; i < s.len(); i++) begin
      write(base + 8'(2 * i), s[i]);
      write(base + 8'(2 * i + 1), 8'h00);
    end
  endtask
endmodule // hdc_ctrl_model
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the hub descriptor configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic desc_req = 1'b0;
  logic [1:0] desc_sel = 2'h0;
  logic cfg_wr, cfg_rd, desc_busy, desc_valid, desc_last, desc_done;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, desc_data, cur_self, cur_bus, pwr_good_time;
  logic [15:0] lang_id;
  logic [7:0] rd;
  int bad_count = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  hdc_regs u_hdc_regs (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .desc_req(desc_req),
    .desc_sel(desc_sel), .desc_busy(desc_busy), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_last(desc_last), .desc_done(desc_done),
    .cur_self(cur_self), .cur_bus(cur_bus), .pwr_good_time(pwr_good_time), .lang_id(lang_id));
  hdc_ctrl_model u_hdc_ctrl_model (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_hdc_ctrl_model.read(a, rd);
    chk("cfg_rdata", {8'h00, e}, {8'h00, rd});
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic stream(input logic [1:0] sel, input logic [7:0] exp[$]);
    int n;
    int k;
    n = 0;
    @(posedge clk);
    #1;
    desc_req = 1'b1;
    desc_sel = sel;
    @(posedge clk);
    #1;
    desc_req = 1'b0;
    chk("desc_busy", 16'(exp.size() != 0), {15'h0, desc_busy});
    for (k = 0; k < 100; k++) begin
      if (desc_valid === 1'b1) begin
        chk("desc_data", {8'h00, exp[n]}, {8'h00, desc_data});
        chk("desc_last", 16'(n == exp.size() - 1), {15'h0, desc_last});
        chk("desc_busy", 16'(n != exp.size() - 1), {15'h0, desc_busy});
        chk("desc_done", 16'(n == exp.size() - 1), {15'h0, desc_done});
        n++;
      end
      if (desc_done === 1'b1) break;
      @(posedge clk);
      #1;
    end
    if (k == 100) begin
      bad_count++;
      summarize();
    end
    chk("desc_count", 16'(exp.size()), 16'(n));
  endtask
  task automatic t_reset;
    logic [7:0] rv[8];
    rv = '{8'h02, 8'h64, 8'h00, 8'h04, 8'h09, 8'h00, 8'h00, 8'h00};
    chk("cur_self", 16'h0002, {8'h00, cur_self});
    chk("cur_bus", 16'h0064, {8'h00, cur_bus});
    chk("pwr_good_time", 16'h0000, {8'h00, pwr_good_time});
    chk("lang_id", 16'h0409, lang_id);
    for (int i = 0; i < 8; i++) rd_chk(8'h0e + 8'(i), rv[i]);
    rd_chk(8'h54, 8'h00);
    rd_chk(8'h91, 8'h00);
  endtask
  task automatic t_regs;
    u_hdc_ctrl_model.write(8'h0e, 8'h32);
    u_hdc_ctrl_model.write(8'h0f, 8'hc8);
    u_hdc_ctrl_model.write(8'h10, 8'h05);
    u_hdc_ctrl_model.write(8'h11, 8'h08);
    u_hdc_ctrl_model.write(8'h12, 8'h0c);
    u_hdc_ctrl_model.write(8'h0d, 8'hff);
    chk("cur_self", 16'h0032, {8'h00, cur_self});
    chk("cur_bus", 16'h00c8, {8'h00, cur_bus});
    chk("pwr_good_time", 16'h0005, {8'h00, pwr_good_time});
    chk("lang_id", 16'h080c, lang_id);
    rd_chk(8'h10, 8'h05);
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'hd0, 8'h00);
    u_hdc_ctrl_model.write(8'h0f, 8'h96);
    rd_chk(8'h0f, 8'h96);
    chk("cur_bus", 16'h0096, {8'h00, cur_bus});
  endtask
  task automatic t_strings;
    logic [7:0] q[$];
    u_hdc_ctrl_model.write_text(8'h16, "Hub");
    u_hdc_ctrl_model.write(8'h13, 8'h06);
    u_hdc_ctrl_model.write(8'h53, 8'h5a);
    rd_chk(8'h53, 8'h5a);
    q = {8'h48, 8'h00, 8'h75, 8'h00, 8'h62, 8'h00};
    stream(2'h0, q);
    // longest product string, last byte at the top of its storage
    u_hdc_ctrl_model.write(8'h91, 8'ha5);
    u_hdc_ctrl_model.write(8'h14, 8'h3e);
    q = {};
    for (int i = 0; i < 61; i++) q.push_back(8'h00);
    q.push_back(8'ha5);
    stream(2'h1, q);
    u_hdc_ctrl_model.write(8'h54, 8'h3c);
    rd_chk(8'h54, 8'h3c);
    q = {};
    stream(2'h2, q);
    // serial length past the storage size streams a clamped count
    u_hdc_ctrl_model.write(8'h15, 8'h50);
    rd_chk(8'h15, 8'h50);
    for (int i = 0; i < 62; i++) q.push_back(8'h00);
    stream(2'h2, q);
    q = {};
    stream(2'h3, q);
  endtask
  task automatic t_rerun;
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("cur_self", 16'h0002, {8'h00, cur_self});
    chk("cur_bus", 16'h0064, {8'h00, cur_bus});
    chk("pwr_good_time", 16'h0000, {8'h00, pwr_good_time});
    chk("lang_id", 16'h0409, lang_id);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h54, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_strings();
    t_rerun();
    summarize();
  end
endmodule // tb
`default_nettype wire
